// >>> nvsc_pkg.sv
package nvsc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned ADDR_W        = 15;
  localparam int unsigned DATA_W        = 8;
  // read/write cycle timing, fast grade
  localparam int unsigned T_CYCLE_NS    = 25;
  localparam int unsigned T_CYCLE_CYC   = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_PIN_PULSE_NS  = 15;
  localparam int unsigned T_PIN_PULSE_CYC = (T_PIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // lockout waits, longest times
  localparam int unsigned T_STORE_MS    = 8;
  localparam int unsigned T_HRECALL_MS  = 20;
  localparam int unsigned T_RECALL_US   = 200;
  localparam int unsigned T_SS_US       = 100;
  localparam int unsigned STORE_CYC     = T_STORE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned HRECALL_CYC   = T_HRECALL_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned RECALL_CYC    = T_RECALL_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned SS_CYC        = T_SS_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned WAIT_W        = 20;
  localparam int unsigned SEQ_LEN       = 6;

  typedef enum logic [1:0] {
    NVSC_CMD_READ   = 2'b00,
    NVSC_CMD_WRITE  = 2'b01,
    NVSC_CMD_SOFT   = 2'b10,
    NVSC_CMD_HWSAVE = 2'b11
  } nvsc_cmd_e;
endpackage

// >>> nvsc_timer_if.sv
`timescale 1ns/1ps
interface nvsc_timer_if #(parameter int unsigned W = 20);
  logic         load;
  logic [W-1:0] count;
  logic         done;
  modport ctrl (output load, output count, input done);
  modport tmr  (input load, input count, output done);
endinterface

// >>> nvsc_timer.sv
`timescale 1ns/1ps
module nvsc_timer #(
  parameter int unsigned W = 20
) (
  input  wire logic   i_clk_sys,
  input  wire logic   i_rst,
  nvsc_timer_if.tmr   t
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (t.load) begin
      cnt_next = t.count;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - W'(1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign t.done = (cnt_reg == '0) && !t.load;
endmodule

// >>> nvsc_host.sv
// Function
// - keep write strobe high during reads
// - hold store pin high in memory cycles
// - address changes only with select high
// - six ordered reads, write strobe high
// - each command read at least 25 ns
// - store pulse at least 15 ns
`timescale 1ns/1ps
module nvsc_host #(
  parameter int unsigned HRECALL_CYCLES = nvsc_pkg::HRECALL_CYC,
  parameter int unsigned STORE_CYCLES   = nvsc_pkg::STORE_CYC,
  parameter int unsigned RECALL_CYCLES  = nvsc_pkg::RECALL_CYC,
  parameter int unsigned SS_CYCLES      = nvsc_pkg::SS_CYC
) (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rst,
  input  wire logic                        i_req_valid,
  output logic                             o_req_ready,
  input  wire nvsc_pkg::nvsc_cmd_e         i_req_cmd,
  input  wire logic [nvsc_pkg::ADDR_W-1:0] i_req_addr,
  input  wire logic [nvsc_pkg::DATA_W-1:0] i_req_wdata,
  input  wire logic                        i_req_recall,
  output logic                             o_rsp_valid,
  output logic [nvsc_pkg::DATA_W-1:0]      o_rsp_rdata,
  output logic                             o_busy,
  input  wire logic                        i_power_good,
  output logic [nvsc_pkg::ADDR_W-1:0]      o_addr,
  output logic                             o_chip_sel_n,
  output logic                             o_write_n,
  output logic                             o_out_en_n,
  input  wire logic [nvsc_pkg::DATA_W-1:0] i_dq,
  output logic [nvsc_pkg::DATA_W-1:0]      o_dq,
  output logic                             o_dq_oe,
  input  wire logic                        i_store_busy_pin_n,
  output logic                             o_store_busy_pin_n,
  output logic                             o_store_busy_pin_oe
);
  import nvsc_pkg::*;

  typedef enum logic [3:0] {
    NVSC_IDLE     = 4'b0000,
    NVSC_SETUP    = 4'b0001,
    NVSC_STROBE   = 4'b0010,
    NVSC_HOLD     = 4'b0011,
    NVSC_HW_PULSE = 4'b0100,
    NVSC_HW_WAIT  = 4'b0101,
    NVSC_LOCKOUT  = 4'b0110,
    NVSC_PWRUP    = 4'b0111
  } nvsc_state_e;

  nvsc_state_e             st_reg, st_next;
  logic [ADDR_W-1:0]       addr_reg, addr_next;
  logic [DATA_W-1:0]       wdata_reg, wdata_next;
  logic [DATA_W-1:0]       rdata_reg, rdata_next;
  logic                    is_write_reg, is_write_next;
  logic                    soft_reg, soft_next;
  logic                    recall_reg, recall_next;
  logic [2:0]              seq_reg, seq_next;
  logic [1:0]              ph_reg, ph_next;
  logic                    rsp_reg, rsp_next;
  logic                    cs_n_reg, cs_n_next;
  logic                    we_n_reg, we_n_next;
  logic                    oe_n_reg, oe_n_next;
  logic                    dq_oe_reg, dq_oe_next;
  logic                    pin_drv_reg, pin_drv_next;
  logic                    dirty_reg, dirty_next;
  logic                    pg_q_reg;

  nvsc_timer_if #(.W(WAIT_W)) tif ();

  nvsc_timer #(
    .W(WAIT_W)
  ) u_timer (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .t         (tif)
  );

  localparam logic [1:0]        PH_CYC  = 2'(T_CYCLE_CYC);
  localparam logic [1:0]        PH_PIN  = 2'(T_PIN_PULSE_CYC);
  localparam logic [2:0]        SEQ_LAST = 3'(SEQ_LEN - 1);

  always_comb begin
    st_next       = st_reg;
    addr_next     = addr_reg;
    wdata_next    = wdata_reg;
    rdata_next    = rdata_reg;
    is_write_next = is_write_reg;
    soft_next     = soft_reg;
    recall_next   = recall_reg;
    seq_next      = seq_reg;
    ph_next       = ph_reg;
    rsp_next      = 1'b0;
    cs_n_next     = cs_n_reg;
    we_n_next     = we_n_reg;
    oe_n_next     = oe_n_reg;
    dq_oe_next    = dq_oe_reg;
    pin_drv_next  = 1'b0;
    dirty_next    = dirty_reg;
    tif.load      = 1'b0;
    tif.count     = '0;
    case (st_reg)
      NVSC_PWRUP: begin
        // no cycles until the device has recalled its image
        // supply history unknown after reset, so the full recall wait is taken
        if (!i_power_good || !pg_q_reg) begin
          tif.load  = 1'b1;
          tif.count = WAIT_W'(HRECALL_CYCLES);
        end else if (tif.done) begin
          st_next = NVSC_IDLE;
        end
      end
      NVSC_IDLE: begin
        if (!pg_q_reg) begin
          st_next = NVSC_PWRUP;
        end else if (i_req_valid) begin
          addr_next     = i_req_addr;
          wdata_next    = i_req_wdata;
          is_write_next = (i_req_cmd == NVSC_CMD_WRITE);
          soft_next     = (i_req_cmd == NVSC_CMD_SOFT);
          recall_next   = i_req_recall;
          seq_next      = '0;
          ph_next       = PH_CYC;
          if (i_req_cmd == NVSC_CMD_HWSAVE) begin
            if (dirty_reg) begin
              st_next = NVSC_HW_PULSE;
              ph_next = PH_PIN;
            end else begin
              rsp_next = 1'b1;
            end
          end else begin
            // address settles while select stays high
            st_next = NVSC_SETUP;
          end
        end
      end
      NVSC_SETUP: begin
        cs_n_next  = 1'b0;
        // write strobe only with write data; never low before select falls
        we_n_next  = !is_write_reg;
        oe_n_next  = is_write_reg;
        dq_oe_next = is_write_reg;
        st_next    = NVSC_STROBE;
      end
      NVSC_STROBE: begin
        if (ph_reg > 2'd1) begin
          ph_next = ph_reg - 2'd1;
        end else begin
          if (!is_write_reg) begin
            rdata_next = i_dq;
          end
          cs_n_next = 1'b1;
          we_n_next = 1'b1;
          oe_n_next = 1'b1;
          st_next   = NVSC_HOLD;
        end
      end
      NVSC_HOLD: begin
        dq_oe_next = 1'b0;
        if (is_write_reg) begin
          dirty_next = 1'b1;
        end
        if (soft_reg && seq_reg != SEQ_LAST) begin
          // the caller presents the next command address each read
          seq_next = seq_reg + 3'd1;
          addr_next = i_req_addr;
          st_next  = NVSC_SETUP;
        end else if (soft_reg) begin
          tif.load  = 1'b1;
          tif.count = recall_reg ? WAIT_W'(SS_CYCLES + RECALL_CYCLES)
                                 : WAIT_W'(SS_CYCLES + STORE_CYCLES);
          dirty_next = 1'b0;
          st_next   = NVSC_LOCKOUT;
        end else begin
          rsp_next = 1'b1;
          st_next  = NVSC_IDLE;
        end
      end
      NVSC_HW_PULSE: begin
        // pin stays low for the whole count; the wait state releases it
        pin_drv_next = 1'b1;
        if (ph_reg > 2'd1) begin
          ph_next = ph_reg - 2'd1;
        end else begin
          st_next = NVSC_HW_WAIT;
        end
      end
      NVSC_HW_WAIT: begin
        // device holds store pin low while it saves
        if (i_store_busy_pin_n) begin
          rsp_next   = 1'b1;
          dirty_next = 1'b0;
          st_next    = NVSC_IDLE;
        end
      end
      NVSC_LOCKOUT: begin
        if (tif.done) begin
          rsp_next = 1'b1;
          st_next  = NVSC_IDLE;
        end
      end
      default: begin
        st_next = NVSC_PWRUP;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_reg       <= NVSC_PWRUP;
      addr_reg     <= '0;
      wdata_reg    <= '0;
      rdata_reg    <= '0;
      is_write_reg <= 1'b0;
      soft_reg     <= 1'b0;
      recall_reg   <= 1'b0;
      seq_reg      <= '0;
      ph_reg       <= '0;
      rsp_reg      <= 1'b0;
      cs_n_reg     <= 1'b1;
      we_n_reg     <= 1'b1;
      oe_n_reg     <= 1'b1;
      dq_oe_reg    <= 1'b0;
      pin_drv_reg  <= 1'b0;
      dirty_reg    <= 1'b1;
      pg_q_reg     <= 1'b0;
    end else begin
      st_reg       <= st_next;
      addr_reg     <= addr_next;
      wdata_reg    <= wdata_next;
      rdata_reg    <= rdata_next;
      is_write_reg <= is_write_next;
      soft_reg     <= soft_next;
      recall_reg   <= recall_next;
      seq_reg      <= seq_next;
      ph_reg       <= ph_next;
      rsp_reg      <= rsp_next;
      cs_n_reg     <= cs_n_next;
      we_n_reg     <= we_n_next;
      oe_n_reg     <= oe_n_next;
      dq_oe_reg    <= dq_oe_next;
      pin_drv_reg  <= pin_drv_next;
      dirty_reg    <= dirty_next;
      pg_q_reg     <= i_power_good;
    end
  end

  // store pin released (high) in every memory cycle
  assign o_store_busy_pin_n  = 1'b0;
  assign o_store_busy_pin_oe = pin_drv_reg;
  assign o_addr              = addr_reg;
  assign o_chip_sel_n        = cs_n_reg;
  assign o_write_n           = we_n_reg;
  assign o_out_en_n          = oe_n_reg;
  assign o_dq                = wdata_reg;
  assign o_dq_oe             = dq_oe_reg;
  assign o_req_ready         = (st_reg == NVSC_IDLE) && pg_q_reg;
  assign o_rsp_valid         = rsp_reg;
  assign o_rsp_rdata         = rdata_reg;
  assign o_busy              = (st_reg != NVSC_IDLE);
endmodule

// >>> nvsc_sram_model.sv
`timescale 1ns/1ps
module nvsc_sram_model #(
  parameter logic [14:0] SEQ [6] = '{default: 15'h0},
  parameter int          LOCK    = 8,
  parameter int          STORE   = 20
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_power_good,
  input  wire logic [14:0] i_addr,
  input  wire logic        i_cs_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_hw_req,
  output logic [7:0]       o_dq,
  output logic             o_store_busy_pin_n,
  output logic [2:0]       o_cmd_cnt
);
  logic [7:0] mem [0:32767];
  logic [7:0] last = 8'h00;
  logic       dirty = 1'b0;
  int         lock = LOCK;
  int         seq_i = 0;
  logic       rd;
  logic       busy;
  initial o_cmd_cnt = 3'h0;
  assign rd = !i_cs_n && i_we_n && !i_oe_n;
  assign busy = !i_power_good || lock != 0;
  // undriven bus shows a moving pattern, never the last value
  assign o_dq = (rd && !busy) ? mem[i_addr] : ~last;
  assign o_store_busy_pin_n = !(i_hw_req || busy);
  always @(posedge i_clk_sys) begin
    last <= o_dq;
    if (!i_power_good) lock <= LOCK;
    else if (lock != 0) lock <= lock - 1;
    else if (!i_cs_n && !i_we_n) begin
      mem[i_addr] <= i_dq;
      dirty <= 1'b1;
      seq_i <= 0;
    end else if (i_hw_req) begin
      lock <= dirty ? STORE : 0;
      dirty <= 1'b0;
    end else if (rd) begin
      if (i_addr == SEQ[seq_i] && seq_i == 5) begin
        lock <= LOCK;
        dirty <= 1'b0;
        o_cmd_cnt <= o_cmd_cnt + 3'h1;
        seq_i <= 0;
      end else if (i_addr == SEQ[seq_i]) seq_i <= seq_i + 1;
      else seq_i <= int'(i_addr == SEQ[0]);
    end
  end
endmodule

// >>> nvsc_host_sva.sv
`timescale 1ns/1ps
module nvsc_host_sva (
  input wire logic                        i_clk_sys,
  input wire logic                        i_rst,
  input wire logic                        i_req_valid,
  input wire logic                        o_req_ready,
  input wire nvsc_pkg::nvsc_cmd_e         i_req_cmd,
  input wire logic                        o_rsp_valid,
  input wire logic                        o_busy,
  input wire logic                        i_power_good,
  input wire logic [nvsc_pkg::ADDR_W-1:0] o_addr,
  input wire logic                        o_chip_sel_n,
  input wire logic                        o_write_n,
  input wire logic                        o_out_en_n,
  input wire logic                        o_store_busy_pin_oe
);
  import nvsc_pkg::*;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  logic       soft_reg;
  logic [2:0] rd_reg;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || (i_req_valid && o_req_ready)) begin
      soft_reg <= !i_rst && i_req_cmd == NVSC_CMD_SOFT;
      rd_reg <= 3'h0;
    end else if (!o_chip_sel_n) rd_reg <= rd_reg + 3'h1;
  end
  sequence s_take_read;
    i_req_valid && o_req_ready && i_req_cmd == NVSC_CMD_READ;
  endsequence
  sequence s_read_strobe;
    !o_chip_sel_n && !o_out_en_n && o_write_n;
  endsequence
  a_read_we_high:
    assert property (!o_chip_sel_n && !o_out_en_n |-> o_write_n) else $error("write strobe low in read");
  a_store_pin_quiet:
    assert property (!o_chip_sel_n |-> !o_store_busy_pin_oe) else $error("store pin low in cycle");
  a_addr_steady:
    assert property (!$stable(o_addr) |-> o_chip_sel_n || o_write_n) else $error("address moved in access");
  a_read_walk:
    assert property (s_take_read |=> o_chip_sel_n ##1 s_read_strobe ##1 o_chip_sel_n ##1 o_rsp_valid)
      else $error("read cycle shape wrong");
  a_six_reads:
    assert property (o_rsp_valid && soft_reg |-> rd_reg == 3'h6) else $error("command not six reads");
  a_soft_we_high:
    assert property (soft_reg && !o_chip_sel_n |-> o_write_n && !o_out_en_n) else $error("command read bad");
  a_strobe_width:
    assert property ($fell(o_chip_sel_n) |=> $rose(o_chip_sel_n)) else $error("select width wrong");
  a_pulse_bound:
    assert property ($rose(o_store_busy_pin_oe) |-> ##[1:2] !o_store_busy_pin_oe) else $error("store pulse long");
  a_ready_power:
    assert property (o_req_ready |-> !o_busy && $past(i_power_good)) else $error("ready in bad state");
endmodule
bind nvsc_host nvsc_host_sva u_sva (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_req_valid(i_req_valid),
  .o_req_ready(o_req_ready), .i_req_cmd(i_req_cmd), .o_rsp_valid(o_rsp_valid), .o_busy(o_busy),
  .i_power_good(i_power_good), .o_addr(o_addr), .o_chip_sel_n(o_chip_sel_n), .o_write_n(o_write_n),
  .o_out_en_n(o_out_en_n), .o_store_busy_pin_oe(o_store_busy_pin_oe));

// >>> nvsc_host_tb_top.sv
`timescale 1ns/1ps
module nvsc_host_tb_top;
  import nvsc_pkg::*;
  // arbitrary command addresses for the model, clear of the data addresses used
  localparam logic [14:0] SEQ [6] = '{15'h0101, 15'h0202, 15'h0303, 15'h0404, 15'h0505, 15'h0606};
  logic clk, rst, vld, rdy, rcl, rsp, busy, pg, cs_n, we_n, oe_n, dq_oe, pin_n, pin_oe;
  nvsc_cmd_e cmd;
  logic [14:0] addr, pa;
  logic [7:0] wd, rdat, dq_h, dq_m;
  logic [2:0] cmds;
  int error_cnt = 0, total_checks = 0, cyc = 0;
  nvsc_host #(.HRECALL_CYCLES(10), .STORE_CYCLES(10), .RECALL_CYCLES(10), .SS_CYCLES(10)) dut (
    .i_clk_sys(clk), .i_rst(rst), .i_req_valid(vld), .o_req_ready(rdy), .i_req_cmd(cmd), .i_req_addr(addr),
    .i_req_wdata(wd), .i_req_recall(rcl), .o_rsp_valid(rsp), .o_rsp_rdata(rdat), .o_busy(busy),
    .i_power_good(pg), .o_addr(pa), .o_chip_sel_n(cs_n), .o_write_n(we_n), .o_out_en_n(oe_n),
    .i_dq(dq_oe ? dq_h : dq_m), .o_dq(dq_h), .o_dq_oe(dq_oe), .i_store_busy_pin_n(pin_n),
    .o_store_busy_pin_n(), .o_store_busy_pin_oe(pin_oe));
  nvsc_sram_model #(.SEQ(SEQ)) mdl (.i_clk_sys(clk), .i_power_good(pg), .i_addr(pa), .i_cs_n(cs_n),
    .i_we_n(we_n), .i_oe_n(oe_n), .i_dq(dq_h), .i_hw_req(pin_oe), .o_dq(dq_m),
    .o_store_busy_pin_n(pin_n), .o_cmd_cnt(cmds));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %0h seen %0h", n, e, g);
    end
  endtask
  // command reads step the address after each strobe
  task automatic req(input nvsc_cmd_e c, input logic [14:0] a, input logic [7:0] d, output int lat);
    int n;
    n = 0;
    lat = 0;
    while (rdy !== 1'b1) @(negedge clk);
    vld = 1;
    cmd = c;
    addr = a;
    wd = d;
    @(negedge clk);
    vld = 0;
    // latency counted from the take edge
    lat = 1;
    while (rsp !== 1'b1 && lat < 3000) begin
      if (cs_n === 1'b0) begin
        n++;
        if (n < 6) addr = SEQ[n];
      end
      @(negedge clk);
      lat++;
    end
    // a missing answer must never pass on stale data
    if (rsp !== 1'b1) begin
      error_cnt++;
      $display("FAIL response expected 1 seen %0h", rsp);
    end
  endtask
  task automatic t_write_read;
    int lat;
    for (int i = 0; i < 4; i++) begin
      req(NVSC_CMD_WRITE, 15'h7ffc + 15'(i), 8'h5a ^ 8'(i), lat);
      chk("write latency", 4, lat);
    end
    for (int i = 0; i < 4; i++) begin
      req(NVSC_CMD_READ, 15'h7ffc + 15'(i), 8'h00, lat);
      chk("read data", 8'h5a ^ 8'(i), rdat);
    end
  endtask
  task automatic t_soft;
    int lat;
    for (int i = 0; i < 2; i++) begin
      rcl = 1'(i);
      req(NVSC_CMD_SOFT, SEQ[0], 8'h00, lat);
      chk("command count", i + 1, cmds);
      // six reads of three cycles plus the lockout timer
      chk("command time", 1, lat < 50);
    end
    req(NVSC_CMD_READ, 15'h7ffd, 8'h00, lat);
    chk("read after lockout", 8'h5b, rdat);
  endtask
  task automatic t_hwsave;
    int lat;
    req(NVSC_CMD_WRITE, 15'h0000, 8'ha5, lat);
    req(NVSC_CMD_HWSAVE, 15'h0000, 8'h00, lat);
    chk("dirty store waits", 1, lat > 20);
    req(NVSC_CMD_HWSAVE, 15'h0000, 8'h00, lat);
    chk("clean store skipped", 1, lat < 5);
  endtask
  task automatic t_power;
    int lat;
    pg = 0;
    repeat (3) @(negedge clk);
    chk("ready in low supply", 0, rdy);
    pg = 1;
    repeat (2) @(negedge clk);
    chk("busy in recall", 1, busy);
    req(NVSC_CMD_READ, 15'h0000, 8'h00, lat);
    chk("read after power up", 8'ha5, rdat);
  endtask
  initial begin
    rst = 1;
    vld = 0;
    cmd = NVSC_CMD_READ;
    addr = '0;
    wd = '0;
    rcl = 0;
    pg = 1;
    repeat (10) @(negedge clk);
    rst = 0;
    t_write_read();
    t_soft();
    t_hwsave();
    t_power();
    tally_and_finish();
  end
endmodule
